// [mcu_sfr_model.sv]
// mcu core model driving the special function register bus
`timescale 1ns/1ps
module mcu_sfr_model
  import wwu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [7:0] sfr_rdata_in,
  output sfr_req_s sfr_req_out
);
  initial sfr_req_out = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_req_out <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk_in);
    sfr_req_out <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_req_out <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk_in);
    sfr_req_out <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    #1 d = sfr_rdata_in;
  endtask : rd
  // wait until slow side took the command
  task automatic cmd(input logic [3:0] c);
    logic [7:0] s;
    wr(SFR_CONTROL, {4'h0, c});
    s = 8'h10;
    for (int i = 0; i < 600 && s[CTRL_BUSY_BIT] !== 1'b0; i++) rd(SFR_CONTROL, s);
  endtask : cmd
  task automatic ind_wr(input logic [2:0] a, input logic [15:0] v);
    wr(SFR_DATA_HIGH, v[15:8]);
    wr(SFR_DATA_LOW, v[7:0]);
    cmd({1'b1, a});
  endtask : ind_wr
  task automatic ind_rd(input logic [2:0] a, output logic [15:0] v);
    cmd({1'b0, a});
    rd(SFR_DATA_HIGH, v[15:8]);
    rd(SFR_DATA_LOW, v[7:0]);
  endtask : ind_rd
endmodule : mcu_sfr_model

// [pin_wake_filter.sv]
// per-pin debounce filter and edge detector for pin wakeup
`timescale 1ns/1ps
module pin_wake_filter
  import wwu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic slow_en_in,
  input wire logic deb_en_in,
  input wire logic pin_in,
  input wire pin_cfg_s cfg_in,
  output logic wake_evt_out
);
  typedef struct packed {
    logic filt;
    logic [6:0] cnt;
    logic d1;
    logic d2;
    logic evt;
  } filt_state_s;

  filt_state_s st_ff;
  filt_state_s nxt_st;
  logic [6:0] limit;

  always_comb begin
    nxt_st = st_ff;
    limit = deb_limit(cfg_in.deb_sel);
    nxt_st.evt = 1'b0;
    if (slow_en_in) begin
      if (pin_in == st_ff.filt) begin
        nxt_st.cnt = 7'h00;
      end else if (limit == 7'h00) begin
        nxt_st.filt = pin_in;
        nxt_st.cnt = 7'h00;
      end else if (deb_en_in) begin
        if (st_ff.cnt + 7'h01 >= limit) begin
          nxt_st.filt = pin_in;
          nxt_st.cnt = 7'h00;
        end else begin
          nxt_st.cnt = st_ff.cnt + 7'h01;
        end
      end
      nxt_st.d1 = st_ff.filt;
      nxt_st.d2 = st_ff.d1;
      nxt_st.evt = ((cfg_in.edge_sel & EDGE_RISE_BIT) != 2'h0 && st_ff.d1 && !st_ff.d2) ||
                   ((cfg_in.edge_sel & EDGE_FALL_BIT) != 2'h0 && !st_ff.d1 && st_ff.d2);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wake_evt_out = st_ff.evt;
endmodule : pin_wake_filter

// [watchdog_wakeup_unit.sv]
// watchdog, wakeup timer and pin wakeup behind three indirect sfrs, tick divider in its own direct sfr
`timescale 1ns/1ps
module watchdog_wakeup_unit
  import wwu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire sfr_req_s sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [NUM_PINS-1:0] port0_pin_in,
  output logic slow_clock_out,
  output logic wakeup_interrupt_out,
  output logic wakeup_out,
  output logic mcu_reset_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] data_high;
    logic [7:0] data_low;
    logic ctrl_wr;
    logic [2:0] ctrl_addr;
    logic pending;
    logic [7:0] tick_div;
    logic [8:0] div_cnt;
    logic slow_clk;
    logic [7:0] tick_cnt;
    logic [3:0] deb_cnt;
    logic [3:0] deb_latch;
    logic wd_active;
    logic [15:0] wd_cnt;
    logic wd_fire;
    logic rtc_en;
    logic [23:0] rtc_cnt;
    logic [23:0] rtc_latch;
    logic rtc_evt;
    logic stat_timer;
    logic [NUM_PINS-1:0] stat_pins;
    logic [NUM_PINS*4-1:0] pin_cfg;
  } unit_state_s;

  // mcu write into the indirect control sfr
  function automatic logic is_ctrl_write(input sfr_req_s r);
    return r.wr && (r.addr == SFR_CONTROL);
  endfunction : is_ctrl_write

  // the two status targets share one read
  function automatic logic is_status_addr(input logic [2:0] a);
    return (a == IA_WAKE_A) || (a == IA_WAKE_B);
  endfunction : is_status_addr

  // mcu side byte read, unmapped reads as zero
  function automatic logic [7:0] sfr_read_byte(input unit_state_s s, input logic [7:0] a);
    logic [7:0] b;
    case (a)
      SFR_DATA_HIGH: begin
        b = s.data_high;
      end
      SFR_DATA_LOW: begin
        b = s.data_low;
      end
      SFR_CONTROL: begin
        b = {3'h0, s.pending, s.ctrl_wr, s.ctrl_addr};
      end
      SFR_TICK_DIV: begin
        b = s.tick_div;
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction : sfr_read_byte

  // indirect read word presented in the data pair
  function automatic logic [15:0] ind_read_word(input unit_state_s s, input logic [2:0] a);
    logic [15:0] w;
    case (a)
      IA_WDOG: begin
        w = s.wd_cnt;
      end
      IA_TIMER_HIGH: begin
        w = {s.rtc_cnt[23:16], s.rtc_latch[23:16]};
      end
      IA_LATCH_LOW: begin
        w = s.rtc_latch[15:0];
      end
      IA_TIMER_COUNT: begin
        w = s.rtc_cnt[15:0];
      end
      // timer status bit 8, pins 5:0
      IA_WAKE_A, IA_WAKE_B: begin
        w = {7'h00, s.stat_timer, 2'h0, s.stat_pins};
      end
      // reserved targets read as zero
      default: begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction : ind_read_word

  unit_state_s st_ff;
  unit_state_s nxt_st;
  logic slow_en;
  logic tick;
  logic deb_en;
  logic [15:0] cmd_data;
  logic [NUM_PINS-1:0] pin_evt;

  assign slow_en = (st_ff.div_cnt == SLOW_DIV_LAST);
  // tick every divider plus one
  // compare is >= so a lowered divider never waits for a counter wrap
  assign tick = slow_en && (st_ff.tick_cnt >= st_ff.tick_div);
  assign deb_en = slow_en && (st_ff.deb_cnt >= st_ff.deb_latch);
  assign cmd_data = {st_ff.data_high, st_ff.data_low};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      pin_wake_filter u_filter (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .slow_en_in(slow_en),
        .deb_en_in(deb_en),
        .pin_in(port0_pin_in[gi]),
        .cfg_in(st_ff.pin_cfg[gi*4 +: 4]),
        .wake_evt_out(pin_evt[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    // one-cycle pulses default low
    nxt_st.rtc_evt = 1'b0;
    nxt_st.wd_fire = 1'b0;

    // mcu side sfr access
    if (sfr_req_in.wr) begin
      case (sfr_req_in.addr)
        SFR_DATA_HIGH: begin
          nxt_st.data_high = sfr_req_in.wdata;
        end
        SFR_DATA_LOW: begin
          nxt_st.data_low = sfr_req_in.wdata;
        end
        SFR_CONTROL: begin
          nxt_st.ctrl_wr = sfr_req_in.wdata[CTRL_WR_BIT];
          nxt_st.ctrl_addr = sfr_req_in.wdata[2:0];
          nxt_st.pending = 1'b1;
        end
        SFR_TICK_DIV: begin
          // new divider applies from the next slow enable, to the count already running
          nxt_st.tick_div = sfr_req_in.wdata;
        end
        default: begin
          // other sfrs belong to other blocks
        end
      endcase
    end
    if (sfr_req_in.rd) begin
      nxt_st.rdata = sfr_read_byte(st_ff, sfr_req_in.addr);
    end

    // slow clock divider
    if (slow_en) begin
      nxt_st.div_cnt = 9'h000;
      nxt_st.slow_clk = ~st_ff.slow_clk;
      nxt_st.tick_cnt = tick ? 8'h00 : st_ff.tick_cnt + 8'h01;
      nxt_st.deb_cnt = deb_en ? 4'h0 : st_ff.deb_cnt + 4'h1;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 9'h001;
    end

    // both timers step on the same tick
    if (tick) begin
      if (st_ff.rtc_en) begin
        if (st_ff.rtc_cnt == 24'h000000) begin
          nxt_st.rtc_cnt = st_ff.rtc_latch;
          nxt_st.rtc_evt = 1'b1;
        end else begin
          nxt_st.rtc_cnt = st_ff.rtc_cnt - 24'h000001;
        end
      end
      if (st_ff.wd_active) begin
        if (st_ff.wd_cnt == 16'h0000) begin
          nxt_st.wd_fire = 1'b1;
        end else begin
          nxt_st.wd_cnt = st_ff.wd_cnt - 16'h0001;
        end
      end
    end

    // slow domain command capture
    // runs once per slow edge, so busy lasts at most one slow period
    if (slow_en && st_ff.pending) begin
      // a control write in this very cycle stays pending for the next slow edge
      nxt_st.pending = is_ctrl_write(sfr_req_in);
      nxt_st.wd_active = 1'b1;
      if (st_ff.ctrl_wr) begin
        case (st_ff.ctrl_addr)
          IA_WDOG: begin
            nxt_st.wd_cnt = cmd_data;
          end
          IA_TIMER_HIGH: begin
            nxt_st.deb_latch = cmd_data[DEB_LATCH_LSB +: 4];
            nxt_st.rtc_latch[23:16] = st_ff.data_low;
          end
          IA_LATCH_LOW: begin
            nxt_st.rtc_en = 1'b1;
            nxt_st.rtc_latch[15:0] = cmd_data;
            nxt_st.rtc_cnt = {st_ff.rtc_latch[23:16], cmd_data};
            nxt_st.rtc_evt = 1'b0;
          end
          IA_TIMER_COUNT: begin
            nxt_st.rtc_en = 1'b0;
          end
          IA_WAKE_A: begin
            nxt_st.pin_cfg[PINS_CFG_A*4-1:0] = cmd_data;
          end
          IA_WAKE_B: begin
            // pins 4 and 5 from the low byte
            nxt_st.pin_cfg[NUM_PINS*4-1:PINS_CFG_A*4] = st_ff.data_low;
          end
          default: begin
            // reserved targets ignored
          end
        endcase
      end else begin
        {nxt_st.data_high, nxt_st.data_low} = ind_read_word(st_ff, st_ff.ctrl_addr);
        if (is_status_addr(st_ff.ctrl_addr)) begin
          nxt_st.stat_timer = 1'b0;
          nxt_st.stat_pins = '0;
        end
      end
    end

    // sticky status, new events win over clear
    if (st_ff.rtc_evt) begin
      nxt_st.stat_timer = 1'b1;
    end
    nxt_st.stat_pins = nxt_st.stat_pins | pin_evt;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
      // data pair and divider leave reset at their set values
      st_ff.data_high <= DATA_RST;
      st_ff.data_low <= DATA_RST;
      st_ff.tick_div <= TICK_DIV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sfr_rdata_out = st_ff.rdata;
  assign slow_clock_out = st_ff.slow_clk;
  assign wakeup_interrupt_out = st_ff.rtc_evt;
  assign wakeup_out = st_ff.rtc_evt || (st_ff.stat_pins != '0) || st_ff.stat_timer;
  // reset pulse each tick at zero
  assign mcu_reset_out = st_ff.wd_fire;
endmodule : watchdog_wakeup_unit

// [watchdog_wakeup_unit_tb_top.sv]
// self-checking bench of the watchdog and wakeup unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module watchdog_wakeup_unit_tb_top
  import wwu_pkg::*;
;
  logic clk, rst_n, irq, wake, mrst;
  logic [5:0] pins;
  logic [7:0] rdata;
  logic [15:0] v;
  sfr_req_s req;
  int failures = 0, samples_checked = 0, cyc = 0, irqs = 0, rsts = 0, t0, t1, t2;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irqs <= irqs + int'(irq === 1'b1);
    rsts <= rsts + int'(mrst === 1'b1);
  end
  watchdog_wakeup_unit dut (.sys_clk_in(clk), .rst_n_in(rst_n), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .port0_pin_in(pins), .slow_clock_out(), .wakeup_interrupt_out(irq),
    .wakeup_out(wake), .mcu_reset_out(mrst));
  mcu_sfr_model mcu (.sys_clk_in(clk), .sfr_rdata_in(rdata), .sfr_req_out(req));
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_irq(output int t);
    for (int k = 0; k < 6000 && irq !== 1'b1; k++) @(negedge clk);
    t = cyc;
    @(negedge clk);
  endtask : wait_irq
  task automatic pin_step(input logic [5:0] p, input logic [15:0] exp);
    @(posedge clk) pins <= p;
    repeat (500) @(negedge clk);
    `CHK("early_wake", 1'b0, wake)
    repeat (2500) @(negedge clk);
    `CHK("pin_wake", 1'b1, wake)
    mcu.ind_rd(IA_WAKE_B, v);
    `CHK("pin_status", exp, v)
  endtask : pin_step
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    pins = 6'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    mcu.rd(SFR_TICK_DIV, v[7:0]);
    `CHK("tick_div", 8'h03, v[7:0])
    mcu.rd(8'h00, v[7:0]);
    `CHK("unmapped", 8'h00, v[7:0])
    mcu.wr(SFR_TICK_DIV, 8'h00);
    mcu.ind_wr(IA_WDOG, 16'hffff);
    mcu.ind_wr(IA_TIMER_HIGH, 16'h0000);
    mcu.ind_wr(IA_LATCH_LOW, 16'h0003);
    t0 = cyc;
    wait_irq(t1);
    wait_irq(t2);
    `CHK("first_wake", 1'b1, t1 - t0 >= 1500 && t1 - t0 <= 3000)
    `CHK("period", 2000, t2 - t1)
    mcu.ind_wr(IA_TIMER_COUNT, 16'h0000);
    t0 = irqs;
    repeat (3000) @(posedge clk);
    `CHK("disabled", t0, irqs)
    mcu.ind_rd(IA_TIMER_COUNT, v);
    `CHK("timer_frozen", 1'b1, v <= 16'h0003)
    mcu.ind_rd(IA_LATCH_LOW, v);
    `CHK("latch_low", 16'h0003, v)
    mcu.ind_rd(IA_TIMER_HIGH, v);
    `CHK("timer_high", 16'h0000, v)
    mcu.ind_rd(IA_WAKE_A, v);
    `CHK("status", 16'h0100, v)
    mcu.ind_rd(IA_WAKE_A, v);
    `CHK("status_clr", 16'h0000, v)
    mcu.ind_rd(3'h6, v);
    `CHK("reserved", 16'h0000, v)
    mcu.ind_wr(IA_WAKE_A, 16'h0c84);
    mcu.ind_wr(IA_WAKE_B, 16'h0040);
    pin_step(6'h27, 16'h0025);
    pin_step(6'h00, 16'h0006);
    mcu.ind_wr(IA_WAKE_A, 16'h5c84);
    @(posedge clk) pins <= 6'h08;
    repeat (400) @(posedge clk);
    pins <= 6'h00;
    repeat (2500) @(negedge clk);
    `CHK("glitch_wake", 1'b0, wake)
    pin_step(6'h08, 16'h0008);
    `CHK("no_reset", 0, rsts)
    mcu.ind_wr(IA_WDOG, 16'h0004);
    mcu.ind_rd(IA_WDOG, v);
    `CHK("wdog_cnt", 1'b1, v <= 16'h0004 && v >= 16'h0002)
    for (int i = 0; i < 5000 && mrst !== 1'b1; i++) @(negedge clk);
    `CHK("wdog_fire", 1'b1, mrst)
    wrap_up();
  end
endmodule : watchdog_wakeup_unit_tb_top

// [wwu_assertions.sv]
// port-level checks of the watchdog and wakeup unit
`timescale 1ns/1ps
module wwu_assertions
  import wwu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire sfr_req_s sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [NUM_PINS-1:0] port0_pin_in,
  input wire logic slow_clock_out,
  input wire logic wakeup_interrupt_out,
  input wire logic wakeup_out,
  input wire logic mcu_reset_out
);
  logic [9:0] gap_ff;
  logic [7:0] div_ff;
  logic [3:0] ctl_ff;
  logic slow_q_ff, seen_ff, armed_ff, timer_ff, tgl, ctl_wr, ctl_rd;
  assign tgl = slow_clock_out != slow_q_ff;
  assign ctl_wr = sfr_req_in.wr && sfr_req_in.addr == SFR_CONTROL;
  assign ctl_rd = sfr_req_in.rd && sfr_req_in.addr == SFR_CONTROL;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      gap_ff <= '0;
      div_ff <= TICK_DIV_RST;
      ctl_ff <= '0;
      {slow_q_ff, seen_ff, armed_ff, timer_ff} <= '0;
    end else begin
      slow_q_ff <= slow_clock_out;
      gap_ff <= tgl ? 10'h000 : gap_ff + 10'h001;
      seen_ff <= seen_ff | tgl;
      if (sfr_req_in.wr && sfr_req_in.addr == SFR_TICK_DIV) div_ff <= sfr_req_in.wdata;
      if (ctl_wr) ctl_ff <= sfr_req_in.wdata[3:0];
      armed_ff <= armed_ff | ctl_wr;
      timer_ff <= timer_ff | (ctl_wr && sfr_req_in.wdata[3:0] == 4'ha);
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  slow_period_a: assert property (tgl && seen_ff |-> gap_ff == 10'd499)
    else $error("slow clock half period wrong");
  tick_readback_a: assert property (sfr_req_in.rd && sfr_req_in.addr == SFR_TICK_DIV
    |=> sfr_rdata_out == div_ff) else $error("tick divider readback wrong");
  ctl_readback_a: assert property (ctl_rd
    |=> sfr_rdata_out[7:5] == 3'h0 && sfr_rdata_out[3:0] == ctl_ff) else $error("control bad");
  busy_set_a: assert property (ctl_wr ##2 (ctl_rd && !tgl) |=> sfr_rdata_out[CTRL_BUSY_BIT])
    else $error("pending bit not set");
  irq_pulse_a: assert property (wakeup_interrupt_out |=> !wakeup_interrupt_out[*8])
    else $error("timer pulse too long");
  irq_wakes_a: assert property (wakeup_interrupt_out |=> wakeup_out)
    else $error("expiry without wakeup");
  irq_enabled_a: assert property (wakeup_interrupt_out |-> timer_ff)
    else $error("expiry before timer enabled");
  wdog_armed_a: assert property (mcu_reset_out |-> armed_ff)
    else $error("reset before watchdog armed");
  wdog_pulse_a: assert property (mcu_reset_out |=> !mcu_reset_out[*8])
    else $error("reset pulse too long");
  cover property (wakeup_interrupt_out);
  cover property (mcu_reset_out);
  cover property (wakeup_out && !wakeup_interrupt_out);
endmodule : wwu_assertions

bind watchdog_wakeup_unit wwu_assertions chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .port0_pin_in(port0_pin_in),
  .slow_clock_out(slow_clock_out), .wakeup_interrupt_out(wakeup_interrupt_out),
  .wakeup_out(wakeup_out), .mcu_reset_out(mcu_reset_out));

// [wwu_pkg.sv]
// constants, register map and carrier types of the watchdog and wakeup unit
package wwu_pkg;
  localparam int SLOW_DIV = 500;
  localparam logic [8:0] SLOW_DIV_LAST = 9'(SLOW_DIV - 1);
  localparam logic [7:0] SFR_DATA_HIGH = 8'hab;
  localparam logic [7:0] SFR_DATA_LOW = 8'hac;
  localparam logic [7:0] SFR_CONTROL = 8'had;
  localparam logic [7:0] SFR_TICK_DIV = 8'hb5;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] TICK_DIV_RST = 8'h03;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_WR_BIT = 3;
  localparam logic [2:0] IA_WDOG = 3'h0;
  localparam logic [2:0] IA_TIMER_HIGH = 3'h1;
  localparam logic [2:0] IA_LATCH_LOW = 3'h2;
  localparam logic [2:0] IA_TIMER_COUNT = 3'h3;
  localparam logic [2:0] IA_WAKE_A = 3'h4;
  localparam logic [2:0] IA_WAKE_B = 3'h5;
  localparam int NUM_PINS = 6;
  localparam int PINS_CFG_A = 4;
  localparam int STAT_TIMER_BIT = 8;
  localparam int DEB_LATCH_LSB = 8;
  localparam logic [1:0] EDGE_RISE_BIT = 2'h1;
  localparam logic [1:0] EDGE_FALL_BIT = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] deb_sel;
  } pin_cfg_s;

  // debounce code to number of stable pulses
  function automatic logic [6:0] deb_limit(input logic [1:0] code);
    case (code)
      2'h0: deb_limit = 7'h00;
      2'h1: deb_limit = 7'h02;
      2'h2: deb_limit = 7'h08;
      default: deb_limit = 7'h40;
    endcase
  endfunction : deb_limit
endpackage : wwu_pkg
